// *** logic/pin_mux_map.svh ***
// register offsets, field positions, reset values of the pin-function mux
// assumes inclusion by bare name from the design files under logic/
//
// Behaviour
// - serial out keeper on when D4 is 0
// - serial out D3-D1: off, codec data, gpo
// - serial out codes 011-111 route internal signals
// - serial out gpo level follows D0
// - serial in D2-D1 mode, D0 reads level
// - spi data out D4-D1: off, spi, gpo
// - spi data out codes 0011-1010 route signals
// - spi data out gpo level follows D0
// - spi clock D2-D1 selects pin use
// - spi clock D0 reads pin, writes ignored
// - general input one D6-D5 mode, D4 level
// - general input two D2-D1 mode, D0 level
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define SERIAL_OUT_PIN_CONTROL 7'h35
`define SERIAL_IN_PIN_CONTROL 7'h36
`define SPI_DATA_OUT_PIN_CONTROL 7'h37
`define SPI_CLOCK_PIN_CONTROL 7'h38
`define GENERAL_INPUTS_PIN_CONTROL 7'h39

// ****************************************
// reset values
// ****************************************
`define SERIAL_OUT_RESET 8'h12
`define SERIAL_IN_MODE_RESET 2'h1
`define SPI_DATA_OUT_RESET 8'h02
`define SPI_CLOCK_MODE_RESET 2'h1
`define GENERAL_INPUTS_RESET 8'h00

// ****************************************
// field positions
// ****************************************
`define KEEPER_OFF_BIT 4
`define GPO_LEVEL_BIT 0
`define SERIAL_OUT_SEL_HI 3
`define SPI_OUT_SEL_HI 4
`define MODE_LO 1
`define MODE_HI 2
`define INPUT_ONE_MODE_LO 5
`define INPUT_ONE_MODE_HI 6
`define INPUT_ONE_LEVEL_BIT 4
`define INPUT_ONE_RESERVED_BIT 7
`define INPUT_TWO_RESERVED_BIT 3

// ****************************************
// two-bit input modes
// ****************************************
`define IN_OFF 2'h0
`define IN_MAIN 2'h1
`define IN_GENERAL 2'h2
`define IN_ALT 2'h3

`endif

// *** logic/pin_mux_pkg.sv ***
// types shared by the pin-function mux
// assumes nothing of its surroundings
package pin_mux_pkg;

   typedef logic [7:0] reg_byte_t;
   typedef logic [6:0] reg_addr_t;
   typedef logic [1:0] in_mode_t;

endpackage

// *** logic/input_sync.sv ***
// three-stage synchroniser with agreement filter for pin inputs
// assumes asynchronous pins and one clock
module input_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);

   // ****************************************
   // per-pin stages
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               s1 <= 1'h0;
               s2 <= 1'h0;
               s3 <= 1'h0;
               level[i] <= 1'h0;
            end else begin
               s1 <= pin[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  level[i] <= s3;
               end
            end
         end
      end
   endgenerate

endmodule

// *** logic/pin_mux.sv ***
// pin-function multiplexer with its five control registers
// assumes a host control port giving single-cycle read and write strobes
`include "pin_mux_map.svh"

module pin_mux (
   input wire logic clk,
   input wire logic reset_n,
   // control port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire pin_mux_pkg::reg_addr_t reg_addr,
   input wire pin_mux_pkg::reg_byte_t reg_wdata,
   output pin_mux_pkg::reg_byte_t reg_rdata,
   input wire logic i2c_selected,
   // internal sources
   input wire logic codec_serial_data_out,
   input wire logic spi_serial_data_out,
   input wire logic clock_output_signal,
   input wire logic interrupt_line_one,
   input wire logic interrupt_line_two,
   input wire logic secondary_bit_clock_out,
   input wire logic secondary_word_clock_out,
   input wire logic secondary_serial_data_out,
   input wire logic record_word_clock,
   input wire logic mic_modulator_clock,
   // output pins
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe_n,
   output logic serial_out_keeper_en,
   output logic spi_data_out_pin_o,
   output logic spi_data_out_pin_oe_n,
   // input pins
   input wire logic serial_in_pin,
   input wire logic spi_clock_pin,
   input wire logic general_input_one,
   input wire logic general_input_two,
   // input buffer enables
   output logic serial_in_buffer_en,
   output logic spi_clock_buffer_en,
   output logic general_input_one_buffer_en,
   output logic general_input_two_buffer_en,
   // routed inputs to internal blocks
   output logic codec_data_in,
   output logic spi_clock_in,
   output logic spi_clock_alt_in,
   output logic general_input_one_alt_in,
   output logic general_input_two_alt_in,
   output logic headphone_speaker_select_input
);

   // ****************************************
   // control registers
   // ****************************************
   pin_mux_pkg::reg_byte_t serial_out_ctl;
   pin_mux_pkg::reg_byte_t spi_out_ctl;
   logic [7:1] serial_in_ctl;
   logic [7:1] spi_clock_ctl;
   logic [7:0] inputs_ctl;

   // ****************************************
   // synchronised pin levels
   // ****************************************
   logic [3:0] level;

   input_sync #(.WIDTH(4)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin({general_input_two, general_input_one, spi_clock_pin, serial_in_pin}),
      .level(level)
   );

   // ****************************************
   // decode
   // ****************************************
   function automatic logic hit(input pin_mux_pkg::reg_addr_t a, input logic [6:0] off);
      hit = (a == off);
   endfunction

   wire wr_serial_out = reg_write && hit(reg_addr, `SERIAL_OUT_PIN_CONTROL);
   wire wr_serial_in = reg_write && hit(reg_addr, `SERIAL_IN_PIN_CONTROL);
   wire wr_spi_out = reg_write && hit(reg_addr, `SPI_DATA_OUT_PIN_CONTROL);
   wire wr_spi_clock = reg_write && hit(reg_addr, `SPI_CLOCK_PIN_CONTROL);
   wire wr_inputs = reg_write && hit(reg_addr, `GENERAL_INPUTS_PIN_CONTROL);

   wire [2:0] serial_out_sel = serial_out_ctl[`SERIAL_OUT_SEL_HI:`MODE_LO];
   wire [3:0] spi_out_sel = spi_out_ctl[`SPI_OUT_SEL_HI:`MODE_LO];
   wire [1:0] serial_in_mode = serial_in_ctl[`MODE_HI:`MODE_LO];
   wire [1:0] spi_clock_mode = spi_clock_ctl[`MODE_HI:`MODE_LO];
   wire [1:0] one_mode = inputs_ctl[`INPUT_ONE_MODE_HI:`INPUT_ONE_MODE_LO];
   wire [1:0] two_mode = inputs_ctl[`MODE_HI:`MODE_LO];

   // ****************************************
   // serial out selection
   // ****************************************
   logic next_serial_out;
   logic next_serial_out_on;
   always_comb begin
      next_serial_out_on = 1'h1;
      case (serial_out_sel)
         3'h0: begin
            next_serial_out = 1'h0;
            next_serial_out_on = 1'h0;
         end
         3'h1: next_serial_out = codec_serial_data_out;
         3'h2: next_serial_out = serial_out_ctl[`GPO_LEVEL_BIT];
         3'h3: next_serial_out = clock_output_signal;
         3'h4: next_serial_out = interrupt_line_one;
         3'h5: next_serial_out = interrupt_line_two;
         3'h6: next_serial_out = secondary_bit_clock_out;
         3'h7: next_serial_out = secondary_word_clock_out;
         default: next_serial_out = 1'h0;
      endcase
   end

   // ****************************************
   // spi data out selection
   // ****************************************
   logic next_spi_out;
   logic next_spi_out_on;
   always_comb begin
      next_spi_out_on = 1'h1;
      case (spi_out_sel)
         4'h1: begin
            next_spi_out = spi_serial_data_out;
            next_spi_out_on = !i2c_selected;
         end
         4'h2: next_spi_out = spi_out_ctl[`GPO_LEVEL_BIT];
         4'h3: next_spi_out = clock_output_signal;
         4'h4: next_spi_out = interrupt_line_one;
         4'h5: next_spi_out = interrupt_line_two;
         4'h6: next_spi_out = record_word_clock;
         4'h7: next_spi_out = mic_modulator_clock;
         4'h8: next_spi_out = secondary_serial_data_out;
         4'h9: next_spi_out = secondary_bit_clock_out;
         4'hA: next_spi_out = secondary_word_clock_out;
         default: begin
            next_spi_out = 1'h0;
            next_spi_out_on = 1'h0;
         end
      endcase
   end

   // ****************************************
   // readback
   // ****************************************
   pin_mux_pkg::reg_byte_t next_rdata;
   always_comb begin
      case (reg_addr)
         `SERIAL_OUT_PIN_CONTROL: next_rdata = serial_out_ctl;
         `SERIAL_IN_PIN_CONTROL: next_rdata = {serial_in_ctl, level[0]};
         `SPI_DATA_OUT_PIN_CONTROL: next_rdata = spi_out_ctl;
         `SPI_CLOCK_PIN_CONTROL: next_rdata = {spi_clock_ctl, level[1]};
         `GENERAL_INPUTS_PIN_CONTROL: next_rdata = {inputs_ctl[7:5], level[2],
            inputs_ctl[3:1], level[3]};
         default: next_rdata = 8'h00;
      endcase
   end

   // ****************************************
   // register writes
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         serial_out_ctl <= `SERIAL_OUT_RESET;
         serial_in_ctl <= {5'h00, `SERIAL_IN_MODE_RESET};
         spi_out_ctl <= `SPI_DATA_OUT_RESET;
         spi_clock_ctl <= {5'h00, `SPI_CLOCK_MODE_RESET};
         inputs_ctl <= `GENERAL_INPUTS_RESET;
         reg_rdata <= 8'h00;
      end else begin
         if (wr_serial_out) serial_out_ctl <= reg_wdata;
         if (wr_serial_in) serial_in_ctl <= reg_wdata[7:1];
         if (wr_spi_out) spi_out_ctl <= reg_wdata;
         if (wr_spi_clock) spi_clock_ctl <= reg_wdata[7:1];
         if (wr_inputs) inputs_ctl <= {reg_wdata[7:5], 1'h0, reg_wdata[3:1], 1'h0};
         if (reg_read) reg_rdata <= next_rdata;
      end
   end

   // ****************************************
   // pin drive, updated the cycle after a write
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         serial_out_pin_o <= 1'h0;
         serial_out_pin_oe_n <= 1'h1;
         serial_out_keeper_en <= 1'h0;
         spi_data_out_pin_o <= 1'h0;
         spi_data_out_pin_oe_n <= 1'h1;
      end else begin
         serial_out_pin_o <= next_serial_out;
         serial_out_pin_oe_n <= !next_serial_out_on;
         serial_out_keeper_en <= !serial_out_ctl[`KEEPER_OFF_BIT];
         spi_data_out_pin_o <= next_spi_out;
         spi_data_out_pin_oe_n <= !next_spi_out_on;
      end
   end

   // ****************************************
   // input buffers and routing
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         serial_in_buffer_en <= 1'h0;
         spi_clock_buffer_en <= 1'h0;
         general_input_one_buffer_en <= 1'h0;
         general_input_two_buffer_en <= 1'h0;
         codec_data_in <= 1'h0;
         spi_clock_in <= 1'h0;
         spi_clock_alt_in <= 1'h0;
         general_input_one_alt_in <= 1'h0;
         general_input_two_alt_in <= 1'h0;
         headphone_speaker_select_input <= 1'h0;
      end else begin
         serial_in_buffer_en <= serial_in_mode == `IN_MAIN || serial_in_mode == `IN_GENERAL;
         spi_clock_buffer_en <= spi_clock_mode != `IN_OFF;
         general_input_one_buffer_en <= one_mode == `IN_MAIN || one_mode == `IN_GENERAL;
         general_input_two_buffer_en <= two_mode != `IN_OFF;
         codec_data_in <= serial_in_mode == `IN_MAIN && level[0];
         spi_clock_in <= spi_clock_mode == `IN_MAIN && level[1];
         spi_clock_alt_in <= spi_clock_mode == `IN_ALT && level[1];
         general_input_one_alt_in <= one_mode == `IN_MAIN && level[2];
         general_input_two_alt_in <= two_mode == `IN_MAIN && level[3];
         headphone_speaker_select_input <= two_mode == `IN_ALT && level[3];
      end
   end

endmodule

// *** tb/pin_world.sv ***
// external parts driving the four input pins of the mux
// assumes the bench sets the wanted pin levels
module pin_world (
   input wire logic [3:0] level,
   output logic serial_in_pin,
   output logic spi_clock_pin,
   output logic general_input_one,
   output logic general_input_two
);
   timeunit 1ns;
   timeprecision 1ps;
   assign serial_in_pin = level[0];
   assign spi_clock_pin = level[1];
   assign general_input_one = level[2];
   assign general_input_two = level[3];
endmodule

// *** tb/pin_mux_monitor.sv ***
// concurrent checks on the pin mux ports
// assumes binding to pin_mux, writes spaced by 3 or more cycles
module pin_mux_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_write,
   input wire pin_mux_pkg::reg_addr_t reg_addr,
   input wire pin_mux_pkg::reg_byte_t reg_wdata,
   input wire logic i2c_selected,
   input wire logic serial_out_pin_o,
   input wire logic serial_out_pin_oe_n,
   input wire logic serial_out_keeper_en,
   input wire logic spi_data_out_pin_o,
   input wire logic spi_data_out_pin_oe_n,
   input wire logic serial_in_buffer_en,
   input wire logic spi_clock_buffer_en,
   input wire logic general_input_one_buffer_en,
   input wire logic general_input_two_buffer_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   logic so_w, sp_w, si_w, sc_w, gi_w;
   assign so_w = reg_write && reg_addr == 7'h35;
   assign si_w = reg_write && reg_addr == 7'h36;
   assign sp_w = reg_write && reg_addr == 7'h37;
   assign sc_w = reg_write && reg_addr == 7'h38;
   assign gi_w = reg_write && reg_addr == 7'h39;
   chk_keeper_level: assert property (
      so_w |-> ##2 serial_out_keeper_en == !$past(reg_wdata[4], 2))
      else $error("keeper level wrong");
   chk_so_gpo: assert property (
      so_w && reg_wdata[3:1] == 3'h2 |-> ##2
      !serial_out_pin_oe_n && serial_out_pin_o == $past(reg_wdata[0], 2))
      else $error("serial out gpo wrong");
   chk_so_off: assert property (
      so_w && reg_wdata[3:1] == 3'h0 |-> ##2 serial_out_pin_oe_n)
      else $error("serial out not off");
   chk_sp_gpo: assert property (
      sp_w && reg_wdata[4:1] == 4'h2 |-> ##2
      !spi_data_out_pin_oe_n && spi_data_out_pin_o == $past(reg_wdata[0], 2))
      else $error("spi out gpo wrong");
   chk_sp_reserved: assert property (
      sp_w && reg_wdata[4:1] > 4'hA |-> ##2 spi_data_out_pin_oe_n)
      else $error("spi out reserved drives");
   chk_sp_i2c_off: assert property (
      sp_w && reg_wdata[4:1] == 4'h1 ##1 i2c_selected |-> ##1 spi_data_out_pin_oe_n)
      else $error("spi out drives under i2c");
   chk_in_buffer: assert property (
      si_w |-> ##2 serial_in_buffer_en == ($past(reg_wdata[2], 2) != $past(reg_wdata[1], 2)))
      else $error("serial in buffer wrong");
   chk_clk_buffer: assert property (
      sc_w |-> ##2 spi_clock_buffer_en == ($past(reg_wdata[2], 2) || $past(reg_wdata[1], 2)))
      else $error("spi clock buffer wrong");
   chk_gin_buffers: assert property (
      gi_w |-> ##2 general_input_two_buffer_en == ($past(reg_wdata[2], 2) || $past(reg_wdata[1], 2))
      && general_input_one_buffer_en == ($past(reg_wdata[6], 2) != $past(reg_wdata[5], 2)))
      else $error("general input buffers wrong");
   cover property (sp_w && reg_wdata[4:1] == 4'h7);
   cover property (so_w && reg_wdata[3:1] == 3'h2);
   cover property (gi_w);
endmodule
bind pin_mux pin_mux_monitor u_monitor (.*);

// *** tb/pin_mux_tb_top.sv ***
// self-checking bench for the pin mux
// assumes pin_world drives the input pins
module pin_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, i2c_selected = 0;
   pin_mux_pkg::reg_addr_t reg_addr = 7'h00;
   pin_mux_pkg::reg_byte_t reg_wdata = 8'h00, reg_rdata;
   logic [9:0] src = 10'h000;
   logic [3:0] level = 4'h0;
   logic codec_serial_data_out, spi_serial_data_out, clock_output_signal, interrupt_line_one;
   logic interrupt_line_two, secondary_bit_clock_out, secondary_word_clock_out;
   logic secondary_serial_data_out, record_word_clock, mic_modulator_clock;
   logic serial_out_pin_o, serial_out_pin_oe_n, serial_out_keeper_en, spi_data_out_pin_o;
   logic spi_data_out_pin_oe_n, serial_in_buffer_en, spi_clock_buffer_en, codec_data_in;
   logic general_input_one_buffer_en, general_input_two_buffer_en, spi_clock_in;
   logic spi_clock_alt_in, general_input_one_alt_in, general_input_two_alt_in;
   logic headphone_speaker_select_input;
   logic serial_in_pin, spi_clock_pin, general_input_one, general_input_two;
   int num_errors = 0, compares = 0;
   int so_map[8] = '{-1, 0, -2, 2, 3, 4, 5, 6};
   int sp_map[16] = '{-1, 1, -2, 2, 3, 4, 8, 9, 7, 5, 6, -1, -1, -1, -1, -1};
   assign {mic_modulator_clock, record_word_clock, secondary_serial_data_out,
      secondary_word_clock_out, secondary_bit_clock_out, interrupt_line_two,
      interrupt_line_one, clock_output_signal, spi_serial_data_out,
      codec_serial_data_out} = src;
   always #12.5 clk = ~clk;
   pin_mux u_dut (.*);
   pin_world u_world (.level(level), .serial_in_pin(serial_in_pin),
      .spi_clock_pin(spi_clock_pin), .general_input_one(general_input_one),
      .general_input_two(general_input_two));
   // ****************************************
   // tasks
   // ****************************************
   task tally_and_finish;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_write = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_write = 0;
      repeat (3) @(negedge clk);
   endtask
   task rd(input logic [6:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_read = 1;
      reg_addr = a;
      @(negedge clk);
      reg_read = 0;
      @(negedge clk);
      chk("rdata", exp, reg_rdata);
   endtask
   function automatic logic [7:0] pin(input bit spi);
      return spi ? {6'h0, spi_data_out_pin_oe_n, spi_data_out_pin_o}
         : {6'h0, serial_out_pin_oe_n, serial_out_pin_o};
   endfunction
   // one output code: off, gpo high, or one-hot routed source
   task out(input logic [6:0] a, input int code, input int m, input bit spi);
      wr(a, 8'(code * 2 + 1));
      if (m == -1)
         chk("pin off", 8'h01, pin(spi) >> 1);
      else if (m == -2)
         chk("pin gpo", 8'h01, pin(spi));
      else begin
         src = 10'(1 << m);
         repeat (2) @(negedge clk);
         chk("pin high", 8'h01, pin(spi));
         src = ~10'(1 << m);
         repeat (2) @(negedge clk);
         chk("pin low", 8'h00, pin(spi));
      end
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (12) @(negedge clk);
      reset_n = 1;
      rd(7'h35, 8'h12);
      rd(7'h37, 8'h02);
      rd(7'h36, 8'h02);
      rd(7'h38, 8'h02);
      rd(7'h39, 8'h00);
      rd(7'h3A, 8'h00);
      chk("keeper", 8'h00, 8'(serial_out_keeper_en));
      for (int c = 0; c < 8; c++) out(7'h35, c, so_map[c], 0);
      for (int c = 0; c < 16; c++) out(7'h37, c, sp_map[c], 1);
      i2c_selected = 1;
      out(7'h37, 1, -1, 1);
      i2c_selected = 0;
      level = 4'hF;
      repeat (8) @(negedge clk);
      chk("spi clock in", 8'h01, 8'(spi_clock_in));
      wr(7'h38, 8'h04);
      rd(7'h38, 8'h05);
      chk("spi clock in", 8'h00, 8'(spi_clock_in));
      wr(7'h38, 8'h06);
      chk("spi clock alt", 8'h01, 8'(spi_clock_alt_in));
      wr(7'h36, 8'h04);
      rd(7'h36, 8'h05);
      chk("codec in", 8'h00, 8'(codec_data_in));
      wr(7'h36, 8'h02);
      chk("codec in", 8'h01, 8'(codec_data_in));
      level = 4'h5;
      repeat (8) @(negedge clk);
      wr(7'h39, 8'h77);
      rd(7'h39, 8'h76);
      wr(7'h39, 8'h06);
      level = 4'hF;
      repeat (8) @(negedge clk);
      chk("hp select", 8'h01, 8'(headphone_speaker_select_input));
      wr(7'h39, 8'h22);
      chk("input one alt", 8'h01, 8'(general_input_one_alt_in));
      chk("input two alt", 8'h01, 8'(general_input_two_alt_in));
      chk("hp select", 8'h00, 8'(headphone_speaker_select_input));
      tally_and_finish;
   end
   initial begin
      #200us;
      num_errors++;
      tally_and_finish;
   end
endmodule
